/* hw/ramp_cmd.sv */
// Purpose: Direct commands for analog preset, receive masking and amplitude measure
// Assumes: APB slave, pready answered in first access cycle, one 10 MHz clock
// Notes: Rules carried out by the logic below
// What this block does
// - Preset loads config from mode and bit rate; skipped in stream modes.
// - Active peer preset sets the single receive channel bit.
// - Target or active initiator preset clears transmitter enable.
// - Active peer preset sets the sync/length framing bit.
// - Preset picks OOK for Type A and peer 106k, AM otherwise.
// - Peer field detector enabled only for active peer mode.
// - Peer clears channel select; demodulator is mixer above fc/16.
// - Preset loads lowpass and zero-setting bits from mode and rate.
// - Stage clipping set only for active peer mode.
// - Forced gain reduction set only for active peer mode.
// - Mask command forces receiver active low and stops framing.
// - Effective masking is command mask OR mask timer running.
// - Unmask command drives receiver active high, framing enabled.
// - Unmask while mask timer runs enables at once and resets timer.
// - Mask and unmask accepted only with receiver enabled.
// - Mask and unmask may be chained and raise no completion interrupt.
// - Measure enables TX and detector, routes to ADC absolute, stores result.
// - Result is 13.02 mVpp per LSB, 3 Vpp gives code E6h.
// - Measurement completes within 25 microseconds.
// - Measure accepted only with oscillator enabled and stable.
// - No command chained after measure; done interrupt raised at end.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module ramp_cmd
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_stable,
    input wire logic mask_timer_running,
    input wire logic [7:0] adc_amplitude_code,
    output logic mask_timer_reset,
    output logic rx_on,
    output logic rx_framing_en,
    output logic tx_en,
    output ramp_pkg::ramp_meas_ctl_type meas_ctl,
    output logic measure_done_irq
);
    import ramp_pkg::*;

    logic [7:0] opc_q;
    logic [7:0] mode_q;
    logic [7:0] rate_q;
    logic [7:0] tas_q;
    logic [7:0] aux_q;
    logic [7:0] rc1_q;
    logic [7:0] rc3_q;
    logic [7:0] adc_q;
    logic cmd_mask_q;
    logic meas_done_q;
    logic mask_reset_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic [8:0] meas_cnt_q;

    typedef enum logic {ST_IDLE, ST_MEASURE} ramp_state_type;
    ramp_state_type state_q;

    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic cmd_wr;
    logic osc_ok;
    logic accept_preset;
    logic accept_mask;
    logic accept_unmask;
    logic accept_measure;
    ramp_mode_type om;
    logic is_peer;
    logic is_target;
    logic [3:0] tx_rate;
    logic [3:0] rx_rate;
    logic rx_masked;
    logic is_preset_code;
    logic is_mask_code;
    logic is_unmask_code;
    logic is_measure_code;

    // Lowpass and zero-setting pattern per receive rate and mode
    function automatic logic [5:0] filter_sel(input ramp_mode_type m, input logic [3:0] r);
        logic [5:0] f;
        f = 6'b000_000;
        case (r)
            RATE_106K: f = (m == OM_TYPE_B) ? 6'b000_100 : 6'b000_000;
            RATE_212K: f = 6'b000_010;
            RATE_424K: f = 6'b010_010;
            RATE_848K: f = 6'b100_001;
            RATE_FC8: f = 6'b101_001;
            RATE_FC4: f = 6'b110_001;
            default: f = 6'b000_000;
        endcase
        return f;
    endfunction

    // Register index from byte address, aligned words only
    function automatic logic [7:0] addr_index(input logic [11:0] a);
        return a[9:2];
    endfunction

    // Only the listed word indices are mapped
    function automatic logic idx_mapped(input logic [7:0] i);
        logic m;
        m = 1'b0;
        case (i)
            IDX_OPERATION_CONTROL: m = 1'b1;
            IDX_MODE_DEFINITION: m = 1'b1;
            IDX_BIT_RATE_DEFINITION: m = 1'b1;
            IDX_TYPE_A_106K_SETTINGS: m = 1'b1;
            IDX_AUXILIARY_DEFINITION: m = 1'b1;
            IDX_RECEIVER_CONFIG_ONE: m = 1'b1;
            IDX_RECEIVER_CONFIG_THREE: m = 1'b1;
            IDX_DIRECT_COMMAND: m = 1'b1;
            IDX_ADC_OUTPUT: m = 1'b1;
            IDX_COMMAND_STATUS: m = 1'b1;
            default: m = 1'b0;
        endcase
        return m;
    endfunction

    // Word index decode, zero wait states
    assign idx = addr_index(paddr);
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && idx_mapped(idx);
    assign pready = penable;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = prdata_q;
    assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
    assign rd_setup = psel && !penable && !pwrite;
    assign wbyte = pwdata[7:0];
    assign cmd_wr = wr_en && (idx == IDX_DIRECT_COMMAND);

    assign om = ramp_mode_type'(mode_q[MOD_OM_LSB +: 4]);
    assign is_target = mode_q[MOD_TARGET];
    assign is_peer = (om == OM_PEER_ACTIVE);
    assign tx_rate = rate_q[7:4];
    assign rx_rate = rate_q[3:0];
    assign osc_ok = opc_q[OPC_OSC_EN] && osc_stable;

    // Command code decode
    always_comb
    begin
        is_preset_code = 1'b0;
        is_mask_code = 1'b0;
        is_unmask_code = 1'b0;
        is_measure_code = 1'b0;
        case (wbyte)
            CMD_ANALOG_PRESET: is_preset_code = 1'b1;
            CMD_MASK_RX: is_mask_code = 1'b1;
            CMD_UNMASK_RX: is_unmask_code = 1'b1;
            CMD_MEASURE_AMPLITUDE: is_measure_code = 1'b1;
            default: is_preset_code = 1'b0;
        endcase
    end

    // A running measurement blocks every other command
    assign accept_preset = cmd_wr && is_preset_code && (state_q == ST_IDLE)
        && (om != OM_SUBCARRIER_STREAM) && (om != OM_BPSK_STREAM);
    assign accept_mask = cmd_wr && is_mask_code && (state_q == ST_IDLE)
        && opc_q[OPC_RX_EN];
    assign accept_unmask = cmd_wr && is_unmask_code && (state_q == ST_IDLE)
        && opc_q[OPC_RX_EN];
    assign accept_measure = cmd_wr && is_measure_code
        && (state_q == ST_IDLE) && osc_ok;

    // Read data captured in the setup phase
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (rd_setup)
        begin
            case (idx)
                IDX_OPERATION_CONTROL: prdata_q <= {24'h00_0000, opc_q};
                IDX_MODE_DEFINITION: prdata_q <= {24'h00_0000, mode_q};
                IDX_BIT_RATE_DEFINITION: prdata_q <= {24'h00_0000, rate_q};
                IDX_TYPE_A_106K_SETTINGS: prdata_q <= {24'h00_0000, tas_q};
                IDX_AUXILIARY_DEFINITION: prdata_q <= {24'h00_0000, aux_q};
                IDX_RECEIVER_CONFIG_ONE: prdata_q <= {24'h00_0000, rc1_q};
                IDX_RECEIVER_CONFIG_THREE: prdata_q <= {24'h00_0000, rc3_q};
                IDX_ADC_OUTPUT: prdata_q <= {24'h00_0000, adc_q};
                IDX_COMMAND_STATUS: prdata_q <= {29'h0000_0000, rx_masked, meas_done_q,
                    (state_q == ST_MEASURE)};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Operation control: software writes, preset edits channel and TX bits
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            opc_q <= RST_REG;
        end
        else if (wr_en && idx == IDX_OPERATION_CONTROL)
        begin
            opc_q <= wbyte;
        end
        else if (accept_preset)
        begin
            if (is_peer)
            begin
                opc_q[OPC_RX_SINGLE_CHANNEL] <= 1'b1;
            end
            if (is_target || is_peer)
            begin
                opc_q[OPC_TX_EN] <= 1'b0;
            end
        end
    end

    // Mode and bit rate definitions
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= RST_REG;
            rate_q <= RST_REG;
        end
        else if (wr_en)
        begin
            if (idx == IDX_MODE_DEFINITION)
            begin
                mode_q <= wbyte;
            end
            if (idx == IDX_BIT_RATE_DEFINITION)
            begin
                rate_q <= wbyte;
            end
        end
    end

    // Preset-loaded configuration registers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tas_q <= RST_REG;
            aux_q <= RST_REG;
            rc1_q <= RST_REG;
            rc3_q <= RST_REG;
        end
        else if (accept_preset)
        begin
            if (is_peer)
            begin
                tas_q[TAS_SYNC_LENGTH_FRAMING] <= 1'b1;
                rc1_q[RC1_CHANNEL_SELECT] <= 1'b0;
            end
            aux_q[AUX_TRANSMIT_MODULATION_AM] <= !((om == OM_TYPE_A) ||
                (is_peer && tx_rate == RATE_106K));
            aux_q[AUX_PEER_FIELD_DETECT_ON] <= is_peer;
            rc1_q[RC1_DEMOD_MIXER] <= (rx_rate == RATE_FC8) || (rx_rate == RATE_FC4);
            {rc1_q[RC1_LOWPASS_LSB +: 3], rc1_q[RC1_ZERO_SET_LSB +: 3]} <=
                filter_sel(om, rx_rate);
            rc3_q[RC3_STAGE_CLIP] <= is_peer;
            rc3_q[RC3_FORCED_GAIN_REDUCTION] <= is_peer;
        end
        else if (wr_en)
        begin
            case (idx)
                IDX_TYPE_A_106K_SETTINGS: tas_q <= wbyte;
                IDX_AUXILIARY_DEFINITION: aux_q <= wbyte;
                IDX_RECEIVER_CONFIG_ONE: rc1_q <= wbyte;
                IDX_RECEIVER_CONFIG_THREE: rc3_q <= wbyte;
                default: tas_q <= tas_q;
            endcase
        end
    end

    // Command-driven receive mask, never signals completion
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd_mask_q <= 1'b0;
            mask_reset_q <= 1'b0;
        end
        else
        begin
            mask_reset_q <= accept_unmask && mask_timer_running;
            if (accept_mask)
            begin
                cmd_mask_q <= 1'b1;
            end
            else if (accept_unmask)
            begin
                cmd_mask_q <= 1'b0;
            end
        end
    end

    // Timer state is ignored during the cycle its reset is pulsed
    assign rx_masked = cmd_mask_q || (mask_timer_running && !mask_reset_q);
    assign rx_on = opc_q[OPC_RX_EN] && !rx_masked;
    assign rx_framing_en = !rx_masked;
    assign mask_timer_reset = mask_reset_q;
    assign tx_en = opc_q[OPC_TX_EN] || (state_q == ST_MEASURE);

    // Analog controls follow the sequencer state
    always_comb
    begin
        meas_ctl.tx_drive_on = (state_q == ST_MEASURE);
        meas_ctl.amp_detector_on = (state_q == ST_MEASURE);
        meas_ctl.adc_route_amplitude = (state_q == ST_MEASURE);
        meas_ctl.adc_absolute_mode = (state_q == ST_MEASURE);
    end

    // Amplitude measurement sequencer
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            meas_cnt_q <= 9'h000;
            adc_q <= RST_REG;
            meas_done_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (accept_measure)
                    begin
                        state_q <= ST_MEASURE;
                        meas_cnt_q <= 9'h000;
                        meas_done_q <= 1'b0;
                    end
                end
                ST_MEASURE:
                begin
                    if (meas_cnt_q == MEASURE_LAST)
                    begin
                        state_q <= ST_IDLE;
                        // Inputs above 3 Vpp saturate at full scale
                        adc_q <= (adc_amplitude_code > AMP_FULL_SCALE_CODE) ?
                            AMP_FULL_SCALE_CODE : adc_amplitude_code;
                        meas_done_q <= 1'b1;
                        irq_q <= 1'b1;
                    end
                    else
                    begin
                        meas_cnt_q <= meas_cnt_q + 9'h001;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign measure_done_irq = irq_q;
endmodule // ramp_cmd
`default_nettype wire

/* hw/ramp_pkg.sv */
// Purpose: Shared constants and types of the direct-command block
// Assumes: 32-bit APB, register byte address is four times the index
// Notes: Mode and rate encodings are local to this block
package ramp_pkg;
    // Register indices, byte address = index * 4
    localparam logic [7:0] IDX_OPERATION_CONTROL = 8'h02;
    localparam logic [7:0] IDX_MODE_DEFINITION = 8'h03;
    localparam logic [7:0] IDX_BIT_RATE_DEFINITION = 8'h04;
    localparam logic [7:0] IDX_TYPE_A_106K_SETTINGS = 8'h05;
    localparam logic [7:0] IDX_AUXILIARY_DEFINITION = 8'h09;
    localparam logic [7:0] IDX_RECEIVER_CONFIG_ONE = 8'h0a;
    localparam logic [7:0] IDX_RECEIVER_CONFIG_THREE = 8'h0c;
    localparam logic [7:0] IDX_DIRECT_COMMAND = 8'h20;
    localparam logic [7:0] IDX_ADC_OUTPUT = 8'h21;
    localparam logic [7:0] IDX_COMMAND_STATUS = 8'h22;

    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;

    // Operation control fields
    localparam int OPC_OSC_EN = 7;
    localparam int OPC_RX_EN = 6;
    localparam int OPC_RX_SINGLE_CHANNEL = 5;
    localparam int OPC_TX_EN = 3;
    // Type A settings field
    localparam int TAS_SYNC_LENGTH_FRAMING = 5;
    // Auxiliary definition fields
    localparam int AUX_TRANSMIT_MODULATION_AM = 5;
    localparam int AUX_PEER_FIELD_DETECT_ON = 4;
    // Receiver config one fields
    localparam int RC1_CHANNEL_SELECT = 7;
    localparam int RC1_DEMOD_MIXER = 6;
    localparam int RC1_LOWPASS_LSB = 3;
    localparam int RC1_ZERO_SET_LSB = 0;
    // Receiver config three fields
    localparam int RC3_STAGE_CLIP = 1;
    localparam int RC3_FORCED_GAIN_REDUCTION = 0;
    // Mode definition fields: target flag and operating mode
    localparam int MOD_TARGET = 7;
    localparam int MOD_OM_LSB = 3;

    typedef enum logic [3:0] {
        OM_PEER_ACTIVE = 4'h0,
        OM_TYPE_A = 4'h1,
        OM_TYPE_B = 4'h2,
        OM_TYPE_F = 4'h3,
        OM_SUBCARRIER_STREAM = 4'he,
        OM_BPSK_STREAM = 4'hf
    } ramp_mode_type;

    // Bit rate codes, fc/128 .. fc/4
    localparam logic [3:0] RATE_106K = 4'h0;
    localparam logic [3:0] RATE_212K = 4'h1;
    localparam logic [3:0] RATE_424K = 4'h2;
    localparam logic [3:0] RATE_848K = 4'h3;
    localparam logic [3:0] RATE_FC8 = 4'h4;
    localparam logic [3:0] RATE_FC4 = 4'h5;

    typedef enum logic [7:0] {
        CMD_ANALOG_PRESET = 8'hcc,
        CMD_MASK_RX = 8'hd0,
        CMD_UNMASK_RX = 8'hd1,
        CMD_MEASURE_AMPLITUDE = 8'hd3
    } ramp_cmd_type;

    // Status fields
    localparam int STA_MEASURE_BUSY = 0;
    localparam int STA_MEASURE_DONE = 1;
    localparam int STA_RX_MASKED = 2;

    // Amplitude result: 13.02 mVpp per LSB, 3 Vpp gives this code
    localparam logic [7:0] AMP_FULL_SCALE_CODE = 8'he6;

    // Timing
    localparam int CLK_FREQ_HZ = 10_000_000;
    localparam int MEASURE_TIME_US = 25;
    localparam int MEASURE_CYCLES = (MEASURE_TIME_US * (CLK_FREQ_HZ / 1_000_000) < 1) ? 1 :
        MEASURE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam logic [8:0] MEASURE_LAST = 9'(MEASURE_CYCLES - 1);

    // Analog controls driven during a measurement
    typedef struct packed {
        logic tx_drive_on;
        logic amp_detector_on;
        logic adc_route_amplitude;
        logic adc_absolute_mode;
    } ramp_meas_ctl_type;
endpackage

/* testbench/ramp_cmd_props.sv */
// Purpose: Port-level checks of the direct-command block
// Assumes: One clock, reset_n asynchronous active low
// Notes: Bound into every ramp_cmd instance
`timescale 1ns/1ns
`default_nettype none
module ramp_cmd_props
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic mask_timer_running,
    input wire logic mask_timer_reset,
    input wire logic rx_on,
    input wire logic rx_framing_en,
    input wire logic tx_en,
    input wire ramp_pkg::ramp_meas_ctl_type meas_ctl,
    input wire logic measure_done_irq
);
    import ramp_pkg::*;
    logic cmd_wr;
    assign cmd_wr = psel && penable && pwrite && pstrb[0] && paddr == 12'h080 && meas_ctl == 4'h0;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_rx_gated: assert property (rx_on |-> rx_framing_en)
        else $error("rx_on high while framing off");
    a_mask_cmd: assert property (
        cmd_wr && pwdata[7:0] == 8'hd0 && rx_on |=> !rx_on && !rx_framing_en)
        else $error("mask command did not mask");
    a_irq_none: assert property (
        cmd_wr && pwdata[7:1] == 7'h68 |=> !measure_done_irq [*2])
        else $error("irq after mask or unmask");
    a_timer_masks: assert property (mask_timer_running && $past(mask_timer_running)
        && !mask_timer_reset && !$past(mask_timer_reset) |-> !rx_framing_en)
        else $error("timer running but not masked");
    a_mtr_pulse: assert property (
        mask_timer_reset |-> rx_framing_en ##1 !mask_timer_reset)
        else $error("timer reset pulse wrong");
    a_meas_on: assert property (meas_ctl != 4'h0 |-> meas_ctl == 4'hf && tx_en)
        else $error("measure controls incomplete");
    a_meas_len: assert property ($rose(meas_ctl.tx_drive_on) |-> ##250 measure_done_irq)
        else $error("measure length wrong");
    a_irq_end: assert property (measure_done_irq |-> $past(meas_ctl) == 4'hf && meas_ctl == 4'h0
        ##1 !measure_done_irq)
        else $error("done irq not at measure end");
    c_meas: cover property ($rose(meas_ctl.tx_drive_on));
    c_mtr: cover property (mask_timer_reset);
    c_mask: cover property (cmd_wr && pwdata[7:0] == 8'hd0 && rx_on);
endmodule // ramp_cmd_props
bind ramp_cmd ramp_cmd_props i_ramp_cmd_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .mask_timer_running(mask_timer_running), .mask_timer_reset(mask_timer_reset),
    .rx_on(rx_on), .rx_framing_en(rx_framing_en), .tx_en(tx_en), .meas_ctl(meas_ctl),
    .measure_done_irq(measure_done_irq));
`default_nettype wire

/* testbench/ramp_analog_model.sv */
// Purpose: Analog side: mask timer, oscillator start-up, amplitude ADC
// Assumes: Timer length and start-up time are arbitrary
// Notes: ADC code follows amp_level unclipped
`timescale 1ns/1ns
`default_nettype none
module ramp_analog_model
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic timer_start,
    input wire logic [7:0] amp_level,
    input wire logic mask_timer_reset,
    input wire logic osc_restart,
    output logic mask_timer_running,
    output logic osc_stable,
    output logic [7:0] adc_amplitude_code
);
    logic [5:0] timer_q;
    logic [3:0] osc_q;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            timer_q <= 6'h00;
        else if (mask_timer_reset)
            timer_q <= 6'h00;
        else if (timer_start)
            timer_q <= 6'h28;
        else if (timer_q != 6'h00)
            timer_q <= timer_q - 6'h01;
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            osc_q <= 4'h0;
        else if (osc_restart)
            osc_q <= 4'h0;
        else if (osc_q != 4'hf)
            osc_q <= osc_q + 4'h1;
    end
    assign mask_timer_running = timer_q != 6'h00;
    assign osc_stable = osc_q == 4'hf;
    assign adc_amplitude_code = amp_level;
endmodule // ramp_analog_model
`default_nettype wire

/* testbench/ramp_cmd_tb.sv */
// Purpose: Self-checking bench of the direct-command block
// Assumes: APB answers when it will; bench waits on pready
// Notes: Values are sampled at the rising edge
`timescale 1ns/1ns
`default_nettype none
module ramp_cmd_tb;
    import ramp_pkg::*;
    logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, osc_stable;
    logic mask_timer_running, mask_timer_reset, rx_on, rx_framing_en, tx_en;
    logic measure_done_irq, timer_start, rerr, osc_restart;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [7:0] adc_amplitude_code, amp_level;
    ramp_meas_ctl_type meas_ctl;
    int fail_count = 0;
    int total_checks = 0;
    int mtr_cnt = 0;
    int irq_cnt = 0;
    ramp_cmd i_ramp_cmd (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_stable(osc_stable),
        .mask_timer_running(mask_timer_running), .adc_amplitude_code(adc_amplitude_code),
        .mask_timer_reset(mask_timer_reset), .rx_on(rx_on), .rx_framing_en(rx_framing_en),
        .tx_en(tx_en), .meas_ctl(meas_ctl), .measure_done_irq(measure_done_irq));
    ramp_analog_model i_ramp_analog_model (.sys_clk(sys_clk), .reset_n(reset_n),
        .timer_start(timer_start), .amp_level(amp_level), .mask_timer_reset(mask_timer_reset),
        .mask_timer_running(mask_timer_running), .osc_stable(osc_stable),
        .adc_amplitude_code(adc_amplitude_code), .osc_restart(osc_restart));
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        if (mask_timer_reset === 1'b1)
            mtr_cnt++;
        if (measure_done_irq === 1'b1)
            irq_cnt++;
    end
    task results;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask
    task rd(input logic [7:0] i, input logic [31:0] e);
        apb(1'b0, i, 8'h00);
        chk(rdat, e);
    endtask
    task preset(input logic [7:0] m, input logic [7:0] r);
        wr(IDX_OPERATION_CONTROL, 8'hc8);
        wr(IDX_MODE_DEFINITION, m);
        wr(IDX_BIT_RATE_DEFINITION, r);
        wr(IDX_DIRECT_COMMAND, CMD_ANALOG_PRESET);
    endtask
    task t_regs;
        rd(IDX_OPERATION_CONTROL, 32'(RST_REG));
        rd(IDX_AUXILIARY_DEFINITION, 32'(RST_REG));
        rd(IDX_RECEIVER_CONFIG_THREE, 32'(RST_REG));
        apb(1'b0, 8'h3f, 8'h00);
        chk({31'h0, rerr}, 32'h1);
        $display("t_regs done");
    endtask
    task t_preset;
        preset(8'h00, 8'h00);
        rd(IDX_OPERATION_CONTROL, 32'he0);
        rd(IDX_TYPE_A_106K_SETTINGS, 32'h20);
        rd(IDX_AUXILIARY_DEFINITION, 32'h10);
        rd(IDX_RECEIVER_CONFIG_ONE, 32'h00);
        rd(IDX_RECEIVER_CONFIG_THREE, 32'h03);
        preset(8'h88, 8'h00);
        rd(IDX_OPERATION_CONTROL, 32'hc0);
        rd(IDX_AUXILIARY_DEFINITION, 32'h00);
        rd(IDX_RECEIVER_CONFIG_THREE, 32'h00);
        preset(8'h10, 8'h14);
        rd(IDX_OPERATION_CONTROL, 32'hc8);
        rd(IDX_AUXILIARY_DEFINITION, 32'h20);
        rd(IDX_RECEIVER_CONFIG_ONE, 32'h69);
        wr(IDX_RECEIVER_CONFIG_ONE, 8'hff);
        preset(8'h00, 8'h23);
        rd(IDX_AUXILIARY_DEFINITION, 32'h30);
        rd(IDX_RECEIVER_CONFIG_ONE, 32'h21);
        preset(8'h10, 8'h00);
        rd(IDX_RECEIVER_CONFIG_ONE, 32'h04);
        preset(8'h18, 8'h11);
        rd(IDX_RECEIVER_CONFIG_ONE, 32'h02);
        for (int m = 14; m < 16; m++)
        begin
            preset(8'(m << 3), 8'h00);
            rd(IDX_AUXILIARY_DEFINITION, 32'h20);
            rd(IDX_RECEIVER_CONFIG_ONE, 32'h02);
        end
        $display("t_preset done");
    endtask
    task t_mask;
        wr(IDX_OPERATION_CONTROL, 8'h80);
        wr(IDX_DIRECT_COMMAND, CMD_MASK_RX);
        chk({31'h0, rx_framing_en}, 32'h1);
        wr(IDX_OPERATION_CONTROL, 8'hc0);
        wr(IDX_DIRECT_COMMAND, CMD_MASK_RX);
        chk({30'h0, rx_on, rx_framing_en}, 32'h0);
        wr(IDX_DIRECT_COMMAND, CMD_UNMASK_RX);
        chk({30'h0, rx_on, rx_framing_en}, 32'h3);
        timer_start <= 1'b1;
        @(posedge sys_clk);
        timer_start <= 1'b0;
        @(posedge sys_clk);
        chk({31'h0, rx_framing_en}, 32'h0);
        wr(IDX_DIRECT_COMMAND, CMD_UNMASK_RX);
        chk({30'h0, rx_on, rx_framing_en}, 32'h3);
        @(posedge sys_clk);
        chk(32'(mtr_cnt), 32'h1);
        chk({31'h0, mask_timer_running}, 32'h0);
        chk(32'(irq_cnt), 32'h0);
        $display("t_mask done");
    endtask
    task meas(input logic [7:0] lvl, input logic [7:0] code);
        int n;
        amp_level <= lvl;
        wr(IDX_DIRECT_COMMAND, CMD_MEASURE_AMPLITUDE);
        chk({27'h0, meas_ctl, tx_en}, 32'h1f);
        n = 1;
        while (measure_done_irq !== 1'b1 && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk(32'(n), 32'(MEASURE_CYCLES + 1));
        rd(IDX_ADC_OUTPUT, {24'h00_0000, code});
    endtask
    task t_meas;
        wr(IDX_OPERATION_CONTROL, 8'h40);
        wr(IDX_DIRECT_COMMAND, CMD_MEASURE_AMPLITUDE);
        chk({28'h0, meas_ctl}, 32'h0);
        wr(IDX_OPERATION_CONTROL, 8'h80);
        osc_restart <= 1'b1;
        @(posedge sys_clk);
        osc_restart <= 1'b0;
        wr(IDX_DIRECT_COMMAND, CMD_MEASURE_AMPLITUDE);
        chk({28'h0, meas_ctl}, 32'h0);
        repeat (16) @(posedge sys_clk);
        meas(8'hff, AMP_FULL_SCALE_CODE);
        rd(IDX_COMMAND_STATUS, 32'h02);
        meas(8'h73, 8'h73);
        chk(32'(irq_cnt), 32'h2);
        $display("t_meas done");
    endtask
    initial
    begin
        #2_000_000;
        fail_count++;
        results();
    end
    initial
    begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        timer_start = 1'b0;
        osc_restart = 1'b0;
        amp_level = 8'h00;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_preset();
        t_mask();
        t_meas();
        results();
    end
endmodule // ramp_cmd_tb
`default_nettype wire
